//--- verilog/wcss_defs.svh
// Constants for the weld controller system settings block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef WCSS_DEFS_SVH
`define WCSS_DEFS_SVH

// ==========================================================
// Setting selectors on the panel and host write ports
`define WCSS_SEL_W              4
`define WCSS_SEL_RATIO          4'h0
`define WCSS_SEL_CHANNELS       4'h1
`define WCSS_SEL_MODE           4'h2
`define WCSS_SEL_EXT_SCHED      4'h3
`define WCSS_SEL_DELAY87        4'h4
`define WCSS_SEL_END_OUT        4'h5
`define WCSS_SEL_STEP_OUT       4'h6
`define WCSS_SEL_WELD_SRC       4'h7
`define WCSS_SEL_AUTO_RESET     4'h8
`define WCSS_SEL_ERROR_OUT      4'h9
`define WCSS_SEL_OWNER          4'hA
`define WCSS_SEL_ADDRESS        4'hB
`define WCSS_SEL_VALVES         4'hC

// ==========================================================
// Value ranges and factory defaults
`define WCSS_RATIO_MIN          8'h01
`define WCSS_RATIO_MAX          8'hC8
`define WCSS_RATIO_DEF          8'h01
`define WCSS_CHANNELS_MIN       4'h1
`define WCSS_CHANNELS_DEF       4'h4
`define WCSS_ADDR_MIN           5'h01
`define WCSS_ADDR_MAX           5'h1E
`define WCSS_ADDR_DEF           5'h01
`define WCSS_VALVES_FEW         4'h4
`define WCSS_VALVES_MANY        4'hC

// ==========================================================
// One-hot regulation mode codes
`define WCSS_MODE_PH_SEC        4'h1
`define WCSS_MODE_PH_PRI        4'h2
`define WCSS_MODE_CC_SEC        4'h4
`define WCSS_MODE_CC_PRI        4'h8

`endif

//--- verilog/wcss_pkg.sv
// Types for the weld controller system settings block.
// Assumes wcss_defs.svh is reachable on the include path.
`include "wcss_defs.svh"

package wcss_pkg;

   // ==========================================================
   // Setting write request, used by panel and host ports
   typedef struct packed {
      logic                     wr;
      logic [`WCSS_SEL_W-1:0]   sel;
      logic [7:0]               data;
   } wcss_wreq_s;

   // ==========================================================
   // Stored configuration
   typedef struct packed {
      logic [7:0] ratio;
      logic [3:0] channels;
      logic [3:0] mode;
      logic       ext_sched;
      logic       delay87;
      logic       end_out;
      logic       step_out;
      logic       weld_remote;
      logic       auto_reset;
      logic       error_out;
      logic       host_owner;
      logic [4:0] address;
      logic [3:0] valves;
   } wcss_cfg_s;

   // ==========================================================
   // Whole state of the block
   typedef struct packed {
      wcss_cfg_s  cfg;
      logic       valve_opt;
      logic       weld_local;
      logic       remote_lock;
      logic       err;
      logic       step_flag;
      logic       first_half;
      logic       start_ok;
      logic       cycle_done;
      logic       step_clear;
      logic [5:0] schedule;
   } wcss_state_s;

endpackage

//--- verilog/wcss_settings.sv
// System-wide settings of a resistance weld controller and their effect
// on schedule choice, firing limit, end, step-end and fault outputs.
// Assumes all inputs are synchronous to i_clock; event inputs are pulses.
`timescale 1ns/100ps
`include "wcss_defs.svh"

module wcss_settings (
   input  wire logic                 i_clock,
   input  wire logic                 i_srst,
   input  wire wcss_pkg::wcss_wreq_s i_panel_req,
   input  wire wcss_pkg::wcss_wreq_s i_host_req,
   input  wire logic                 i_restore_defaults,
   input  wire logic                 i_valve_option_many,
   input  wire logic                 i_sec_coil_present,
   input  wire logic                 i_pri_coil_present,
   input  wire logic [5:0]           i_panel_schedule,
   input  wire logic [5:0]           i_external_schedule_select,
   input  wire logic                 i_weld_start,
   input  wire logic                 i_half_cycle_end,
   input  wire logic                 i_weld_end,
   input  wire logic                 i_step_counts_reached,
   input  wire logic                 i_start,
   input  wire logic                 i_minor_error,
   input  wire logic                 i_panel_reset,
   input  wire logic                 i_reset_input,
   input  wire logic                 i_error_reset,
   input  wire logic                 i_step_reset,
   input  wire logic                 i_panel_weld_toggle,
   input  wire logic                 i_remote_weld_enable_input,
   output logic [7:0]                o_transformer_ratio,
   output logic [3:0]                o_firing_channel_count,
   output logic [3:0]                o_regulation_mode,
   output logic [5:0]                o_schedule,
   output logic                      o_link_enable,
   output logic                      o_fire_limit_87,
   output logic                      o_cycle_complete,
   output logic                      o_stepper_complete,
   output logic                      o_step_counter_clear,
   output logic                      o_weld_enable,
   output logic                      o_start_accept,
   output logic                      o_error_led,
   output logic                      o_fault_output,
   output logic                      o_programming_owner,
   output logic [4:0]                o_unit_address,
   output logic [3:0]                o_valve_count
);

   // ==========================================================
   // Helper functions
   // Factory configuration, shared by reset and restore
   function automatic wcss_pkg::wcss_cfg_s factory_cfg(input logic many);
      wcss_pkg::wcss_cfg_s c;
      c             = '0;
      c.ratio       = `WCSS_RATIO_DEF;
      c.channels    = `WCSS_CHANNELS_DEF;
      c.mode        = `WCSS_MODE_PH_SEC;
      c.ext_sched   = 1'b0;
      c.delay87     = 1'b1;
      c.end_out     = 1'b1;
      c.step_out    = 1'b1;
      c.weld_remote = 1'b0;
      c.auto_reset  = 1'b0;
      c.error_out   = 1'b1;
      c.host_owner  = 1'b0;
      c.address     = `WCSS_ADDR_DEF;
      c.valves      = many ? `WCSS_VALVES_MANY : `WCSS_VALVES_FEW;
      return c;
   endfunction

   // Mode request legal: one-hot and backed by the needed coil
   function automatic logic mode_ok(input logic [3:0] m, input logic sec, input logic pri);
      logic ok;
      ok = 1'b0;
      case (m)
         `WCSS_MODE_PH_SEC: ok = 1'b1;
         `WCSS_MODE_PH_PRI: ok = 1'b1;
         `WCSS_MODE_CC_SEC: ok = sec;
         `WCSS_MODE_CC_PRI: ok = pri;
         default:           ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Apply one write to a configuration, dropping out-of-range values
   function automatic wcss_pkg::wcss_cfg_s apply_wr(input wcss_pkg::wcss_cfg_s c_in,
                                                    input wcss_pkg::wcss_wreq_s r,
                                                    input logic sec,
                                                    input logic pri);
      wcss_pkg::wcss_cfg_s c;
      c = c_in;
      unique case (r.sel)
         `WCSS_SEL_RATIO: begin
            if (r.data >= `WCSS_RATIO_MIN && r.data <= `WCSS_RATIO_MAX) begin
               c.ratio = r.data;
            end
         end
         `WCSS_SEL_CHANNELS: begin
            if (r.data[3:0] >= `WCSS_CHANNELS_MIN && r.data[7:4] == 4'h0) begin
               c.channels = r.data[3:0];
            end
         end
         `WCSS_SEL_MODE: begin
            if (r.data[7:4] == 4'h0 && mode_ok(r.data[3:0], sec, pri)) begin
               c.mode = r.data[3:0];
            end
         end
         `WCSS_SEL_EXT_SCHED:  c.ext_sched   = r.data[0];
         `WCSS_SEL_DELAY87:    c.delay87     = r.data[0];
         `WCSS_SEL_END_OUT:    c.end_out     = r.data[0];
         `WCSS_SEL_STEP_OUT:   c.step_out    = r.data[0];
         `WCSS_SEL_WELD_SRC:   c.weld_remote = r.data[0];
         `WCSS_SEL_AUTO_RESET: c.auto_reset  = r.data[0];
         `WCSS_SEL_ERROR_OUT:  c.error_out   = r.data[0];
         `WCSS_SEL_OWNER:      c.host_owner  = r.data[0];
         `WCSS_SEL_ADDRESS: begin
            if (r.data >= {3'h0, `WCSS_ADDR_MIN} && r.data <= {3'h0, `WCSS_ADDR_MAX}) begin
               c.address = r.data[4:0];
            end
         end
         `WCSS_SEL_VALVES: begin
            if (r.data[3:0] == `WCSS_VALVES_FEW || r.data[3:0] == `WCSS_VALVES_MANY) begin
               if (r.data[7:4] == 4'h0) begin
                  c.valves = r.data[3:0];
               end
            end
         end
         default: c = c_in;  // Unused selectors leave settings alone
      endcase
      return c;
   endfunction

   // ==========================================================
   // State
   wcss_pkg::wcss_state_s state_ff;
   wcss_pkg::wcss_state_s nxt_state;

   logic panel_ok;
   logic err_blocks;

   // Panel may only hand ownership back while the host owns programming
   assign panel_ok = i_panel_req.wr &&
                     (!state_ff.cfg.host_owner ||
                      (i_panel_req.sel == `WCSS_SEL_OWNER && !i_panel_req.data[0]));

   // A latched error holds off start and end only under manual clearing
   assign err_blocks = state_ff.err && !state_ff.cfg.auto_reset;

   // ==========================================================
   // Next-state logic
   always_comb begin
      nxt_state = state_ff;

      // Settings: host first, then panel, so a panel write wins a tie
      if (i_host_req.wr) begin
         nxt_state.cfg = apply_wr(nxt_state.cfg, i_host_req,
                                  i_sec_coil_present, i_pri_coil_present);
      end
      if (panel_ok) begin
         nxt_state.cfg = apply_wr(nxt_state.cfg, i_panel_req,
                                  i_sec_coil_present, i_pri_coil_present);
      end
      if (i_restore_defaults) begin
         nxt_state.cfg = factory_cfg(state_ff.valve_opt);
      end

      // Schedule source; the binary inputs are ignored when off
      nxt_state.schedule = state_ff.cfg.ext_sched ? i_external_schedule_select
                                                  : i_panel_schedule;

      // First half cycle of each weld gets the reduced firing angle
      if (i_weld_start) begin
         nxt_state.first_half = 1'b1;
      end else if (i_half_cycle_end) begin
         nxt_state.first_half = 1'b0;
      end

      // Local weld on/off toggles only while the pushbutton owns it
      if (i_panel_weld_toggle && !state_ff.cfg.weld_remote) begin
         nxt_state.weld_local = !state_ff.weld_local;
      end

      // Remote lock: a panel save forces off until the input opens
      if (panel_ok && state_ff.cfg.weld_remote) begin
         nxt_state.remote_lock = 1'b1;
      end else if (!i_remote_weld_enable_input) begin
         nxt_state.remote_lock = 1'b0;
      end

      // Start is taken unless a manual-clear error is pending
      nxt_state.start_ok = i_start && !err_blocks;

      // Error latch; a new error in a clearing cycle is kept
      if (i_error_reset || i_panel_reset) begin
         nxt_state.err = 1'b0;
      end
      if (i_start && state_ff.cfg.auto_reset) begin
         nxt_state.err = 1'b0;
      end
      if (i_minor_error) begin
         nxt_state.err = 1'b1;
      end

      // End pulse, suppressed when disabled or blocked by an error
      nxt_state.cycle_done = i_weld_end && state_ff.cfg.end_out && !err_blocks;

      // Stepper condition re-raised after any weld with counts reached
      if (i_reset_input || i_panel_reset) begin
         nxt_state.step_flag = 1'b0;
      end
      if (i_step_reset) begin
         nxt_state.step_flag = 1'b0;
      end
      if (i_weld_end && i_step_counts_reached) begin
         nxt_state.step_flag = 1'b1;
      end
      nxt_state.step_clear = i_step_reset;

      if (i_srst) begin
         nxt_state             = '0;
         nxt_state.valve_opt   = i_valve_option_many;  // Strap caught at reset
         nxt_state.cfg         = factory_cfg(i_valve_option_many);
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_clock) begin
      state_ff <= nxt_state;
   end

   // ==========================================================
   // Output registers, derived from next state so each is a flop
   logic                weld_en_nxt;
   logic                fire_lim_nxt;
   logic                step_out_nxt;
   logic                fault_nxt;

   // Unselected source is locked out entirely
   assign weld_en_nxt  = nxt_state.cfg.weld_remote ?
                         (i_remote_weld_enable_input && !nxt_state.remote_lock)
                         : nxt_state.weld_local;
   assign fire_lim_nxt = nxt_state.first_half && nxt_state.cfg.delay87;
   assign step_out_nxt = nxt_state.step_flag && nxt_state.cfg.step_out;
   assign fault_nxt    = nxt_state.err && nxt_state.cfg.error_out;

   // Registered outputs follow the state register by construction
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_weld_enable      <= 1'b0;
         o_fire_limit_87    <= 1'b0;
         o_stepper_complete <= 1'b0;
         o_fault_output     <= 1'b0;
         o_link_enable      <= 1'b1;
      end else begin
         o_link_enable      <= !nxt_state.cfg.ext_sched;
         o_weld_enable      <= weld_en_nxt;
         o_fire_limit_87    <= fire_lim_nxt;
         o_stepper_complete <= step_out_nxt;
         o_fault_output     <= fault_nxt;
      end
   end

   // Remaining outputs are state fields directly
   assign o_transformer_ratio    = state_ff.cfg.ratio;
   assign o_firing_channel_count = state_ff.cfg.channels;
   assign o_regulation_mode      = state_ff.cfg.mode;
   assign o_schedule             = state_ff.schedule;
   assign o_cycle_complete       = state_ff.cycle_done;
   assign o_step_counter_clear   = state_ff.step_clear;
   assign o_start_accept         = state_ff.start_ok;
   assign o_error_led            = state_ff.err;
   assign o_programming_owner    = state_ff.cfg.host_owner;
   assign o_unit_address         = state_ff.cfg.address;
   assign o_valve_count          = state_ff.cfg.valves;

endmodule

//--- sim/wcss_props.sv
// Port checker for the weld settings block.
// Assumes a bind from the bench top file.
`timescale 1ns/100ps
module wcss_props (
   input wire logic                 i_clock,
   input wire logic                 i_srst,
   input wire wcss_pkg::wcss_wreq_s i_panel_req,
   input wire wcss_pkg::wcss_wreq_s i_host_req,
   input wire logic                 i_restore_defaults,
   input wire logic                 i_weld_start,
   input wire logic                 i_half_cycle_end,
   input wire logic                 i_weld_end,
   input wire logic                 i_start,
   input wire logic                 i_panel_reset,
   input wire logic                 i_reset_input,
   input wire logic                 i_error_reset,
   input wire logic                 i_step_reset,
   input wire logic [7:0]           o_transformer_ratio,
   input wire logic [3:0]           o_regulation_mode,
   input wire logic                 o_fire_limit_87,
   input wire logic                 o_cycle_complete,
   input wire logic                 o_stepper_complete,
   input wire logic                 o_step_counter_clear,
   input wire logic                 o_start_accept,
   input wire logic                 o_error_led,
   input wire logic                 o_fault_output
);
   // ====
   // One clock domain, reset masks all
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   // Setting writes may legally drop the step output
   wire quiet = !(i_panel_req.wr || i_host_req.wr || i_restore_defaults);
   wire step_rst = i_reset_input || i_panel_reset || i_step_reset;
   // ====
   // Output relations
   property p_ratio; o_transformer_ratio inside {[8'h01:8'hC8]}; endproperty
   a_ratio: assert property (p_ratio) else $error("ratio range");
   property p_mode; $onehot(o_regulation_mode); endproperty
   a_mode: assert property (p_mode) else $error("mode not one-hot");
   property p_lim; i_half_cycle_end && !i_weld_start |=> !o_fire_limit_87; endproperty
   a_lim: assert property (p_lim) else $error("limit past half cycle");
   property p_end; o_cycle_complete |-> $past(i_weld_end); endproperty
   a_end: assert property (p_end) else $error("end without weld end");
   property p_step; o_stepper_complete && quiet && !step_rst |=> o_stepper_complete; endproperty
   a_step: assert property (p_step) else $error("step output dropped");
   property p_sclr;
      i_step_reset && !i_weld_end |=> o_step_counter_clear && !o_stepper_complete;
   endproperty
   a_sclr: assert property (p_sclr) else $error("step reset lost");
   property p_acc; o_start_accept |-> $past(i_start); endproperty
   a_acc: assert property (p_acc) else $error("accept without start");
   property p_err;
      o_error_led && !(i_error_reset || i_panel_reset || i_start) |=> o_error_led;
   endproperty
   a_err: assert property (p_err) else $error("error dropped");
   property p_flt; o_fault_output |-> o_error_led; endproperty
   a_flt: assert property (p_flt) else $error("fault without error");
endmodule

//--- sim/wcss_plc.sv
// PLC model on the discrete I/O side.
// Assumes the bench sets wanted levels; one scan of delay.
`timescale 1ns/100ps
module wcss_plc (
   input  wire logic       i_clock,
   input  wire logic [5:0] i_sched_want,
   input  wire logic       i_close_want,
   output logic [5:0]      o_sched = 6'h00,
   output logic            o_weld_closed = 1'b0
);
   // ====
   // Scan: levels move one clock after the request
   always @(posedge i_clock) begin
      o_sched <= i_sched_want;
      o_weld_closed <= i_close_want;
   end
endmodule

//--- sim/tb.sv
// Self-checking bench for the weld settings block.
// Assumes design, PLC model and checker compiled first.
`timescale 1ns/100ps
`include "wcss_defs.svh"
module tb;
   logic                 i_clock = 1'b0;
   logic                 i_srst = 1'b1;
   wcss_pkg::wcss_wreq_s preq = '0;
   wcss_pkg::wcss_wreq_s hreq = '0;
   logic [10:0]          ev = '0;
   logic [1:0]           coil = 2'b00;
   logic                 strap = 1'b0;
   logic                 reached = 1'b0;
   logic                 close_want = 1'b0;
   logic [5:0]           ext_sched;
   logic                 closed;
   logic [7:0]           ratio;
   logic [5:0]           sched;
   logic [4:0]           addr;
   logic [3:0]           chans, mode, valves;
   logic                 link, lim, cyc, stp, sclr, wen, acc, led, flt, own;
   int                   err_total = 0;
   int                   n_compared = 0;
   // Event bits: 0 restore, 1 weld start, 2 half end, 3 weld end, 4 start,
   // 5 minor, 6 panel reset, 7 reset in, 8 error reset, 9 step reset, 10 toggle
   wcss_settings u_dut (
      .i_clock(i_clock), .i_srst(i_srst), .i_panel_req(preq), .i_host_req(hreq),
      .i_restore_defaults(ev[0]), .i_valve_option_many(strap),
      .i_sec_coil_present(coil[0]), .i_pri_coil_present(coil[1]),
      .i_panel_schedule(6'h05), .i_external_schedule_select(ext_sched),
      .i_weld_start(ev[1]), .i_half_cycle_end(ev[2]), .i_weld_end(ev[3]),
      .i_step_counts_reached(reached), .i_start(ev[4]), .i_minor_error(ev[5]),
      .i_panel_reset(ev[6]), .i_reset_input(ev[7]), .i_error_reset(ev[8]),
      .i_step_reset(ev[9]), .i_panel_weld_toggle(ev[10]),
      .i_remote_weld_enable_input(closed), .o_transformer_ratio(ratio),
      .o_firing_channel_count(chans), .o_regulation_mode(mode), .o_schedule(sched),
      .o_link_enable(link), .o_fire_limit_87(lim), .o_cycle_complete(cyc),
      .o_stepper_complete(stp), .o_step_counter_clear(sclr), .o_weld_enable(wen),
      .o_start_accept(acc), .o_error_led(led), .o_fault_output(flt),
      .o_programming_owner(own), .o_unit_address(addr), .o_valve_count(valves));
   wcss_plc u_plc (.i_clock(i_clock), .i_sched_want(6'h09), .i_close_want(close_want),
      .o_sched(ext_sched), .o_weld_closed(closed));
   // ====
   // Clock and access tasks
   always #5 i_clock = ~i_clock;
   task automatic tick;
      @(posedge i_clock);
      #1;
   endtask
   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Idle cycle first, so a strobe is never reassigned in one step
   task automatic pe(input int k);
      tick;
      ev[k] = 1'b1;
      tick;
      ev[k] = 1'b0;
   endtask
   task automatic wc(input logic h, input logic [3:0] s, input logic [7:0] d,
                     input logic [7:0] e);
      tick;
      if (h) hreq = {1'b1, s, d};
      else preq = {1'b1, s, d};
      tick;
      hreq.wr = 1'b0;
      preq.wr = 1'b0;
      case (s)
         `WCSS_SEL_RATIO:    ck(ratio, e);
         `WCSS_SEL_CHANNELS: ck({4'h0, chans}, e);
         `WCSS_SEL_MODE:     ck({4'h0, mode}, e);
         `WCSS_SEL_ADDRESS:  ck({3'h0, addr}, e);
         `WCSS_SEL_VALVES:   ck({4'h0, valves}, e);
         `WCSS_SEL_OWNER:    ck({7'h0, own}, e);
         `WCSS_SEL_EXT_SCHED: ck({7'h0, link}, e);
         default: ;
      endcase
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ====
   // Tests; expected figures come from the ranges and defaults
   initial begin
      repeat (5) @(posedge i_clock);
      #1;
      i_srst = 1'b0;
      ck(ratio, 8'h01);
      ck({4'h0, chans}, 8'h04);
      ck({4'h0, mode}, 8'h01);
      ck({3'h0, addr}, 8'h01);
      ck({4'h0, valves}, 8'h04);
      wc(0, `WCSS_SEL_RATIO, 8'hC8, 8'hC8);
      wc(0, `WCSS_SEL_RATIO, 8'hC9, 8'hC8);
      wc(0, `WCSS_SEL_RATIO, 8'h00, 8'hC8);
      // Same-cycle writes: the panel value is the one kept
      tick;
      hreq = {1'b1, `WCSS_SEL_RATIO, 8'h10};
      preq = {1'b1, `WCSS_SEL_RATIO, 8'h20};
      tick;
      hreq.wr = 1'b0;
      preq.wr = 1'b0;
      ck(ratio, 8'h20);
      wc(1, `WCSS_SEL_ADDRESS, 8'h1E, 8'h1E);
      wc(1, `WCSS_SEL_ADDRESS, 8'h1F, 8'h1E);
      wc(0, `WCSS_SEL_CHANNELS, 8'h02, 8'h02);
      wc(0, `WCSS_SEL_VALVES, 8'h0C, 8'h0C);
      wc(0, `WCSS_SEL_VALVES, 8'h05, 8'h0C);
      $display("test 1 done");
      // Each coil unlocks only its own constant-current mode
      wc(0, `WCSS_SEL_MODE, 8'h04, 8'h01);
      wc(0, `WCSS_SEL_MODE, 8'h08, 8'h01);
      coil = 2'b01;
      wc(0, `WCSS_SEL_MODE, 8'h08, 8'h01);
      wc(0, `WCSS_SEL_MODE, 8'h04, 8'h04);
      coil = 2'b10;
      wc(0, `WCSS_SEL_MODE, 8'h08, 8'h08);
      wc(0, `WCSS_SEL_MODE, 8'h04, 8'h08);
      coil = 2'b11;
      for (int i = 0; i < 4; i++) begin
         wc(0, `WCSS_SEL_MODE, 8'h08 >> i, 8'h08 >> i);
      end
      wc(0, `WCSS_SEL_MODE, 8'h03, 8'h01);
      $display("test 2 done");
      ck({2'h0, sched}, 8'h05);
      wc(0, `WCSS_SEL_EXT_SCHED, 8'h01, 8'h00);
      tick;
      ck({2'h0, sched}, 8'h09);
      pe(1);
      ck({7'h0, lim}, 8'h01);
      pe(2);
      ck({7'h0, lim}, 8'h00);
      wc(0, `WCSS_SEL_DELAY87, 8'h00, 8'h00);
      pe(1);
      ck({7'h0, lim}, 8'h00);
      $display("test 3 done");
      pe(3);
      ck({7'h0, cyc}, 8'h01);
      tick;
      ck({7'h0, cyc}, 8'h00);
      wc(0, `WCSS_SEL_END_OUT, 8'h00, 8'h00);
      pe(3);
      ck({7'h0, cyc}, 8'h00);
      wc(0, `WCSS_SEL_END_OUT, 8'h01, 8'h00);
      reached = 1'b1;
      pe(3);
      ck({7'h0, stp}, 8'h01);
      pe(6);
      ck({7'h0, stp}, 8'h00);
      pe(3);
      ck({7'h0, stp}, 8'h01);
      pe(7);
      ck({7'h0, stp}, 8'h00);
      pe(3);
      pe(9);
      ck({7'h0, sclr}, 8'h01);
      ck({7'h0, stp}, 8'h00);
      reached = 1'b0;
      pe(3);
      ck({7'h0, stp}, 8'h00);
      reached = 1'b1;
      wc(0, `WCSS_SEL_STEP_OUT, 8'h00, 8'h00);
      pe(3);
      ck({7'h0, stp}, 8'h00);
      $display("test 4 done");
      pe(5);
      ck({7'h0, led}, 8'h01);
      ck({7'h0, flt}, 8'h01);
      pe(4);
      ck({7'h0, acc}, 8'h00);
      pe(3);
      ck({7'h0, cyc}, 8'h00);
      pe(8);
      ck({7'h0, led}, 8'h00);
      pe(5);
      pe(6);
      ck({7'h0, led}, 8'h00);
      wc(0, `WCSS_SEL_ERROR_OUT, 8'h00, 8'h00);
      pe(5);
      ck({7'h0, flt}, 8'h00);
      wc(0, `WCSS_SEL_AUTO_RESET, 8'h01, 8'h00);
      pe(4);
      ck({7'h0, acc}, 8'h01);
      ck({7'h0, led}, 8'h00);
      $display("test 5 done");
      close_want = 1'b1;
      pe(10);
      ck({7'h0, wen}, 8'h01);
      pe(10);
      ck({7'h0, wen}, 8'h00);
      close_want = 1'b0;
      wc(1, `WCSS_SEL_WELD_SRC, 8'h01, 8'h00);
      repeat (3) tick;
      close_want = 1'b1;
      repeat (3) tick;
      ck({7'h0, wen}, 8'h01);
      pe(10);
      ck({7'h0, wen}, 8'h01);
      wc(0, `WCSS_SEL_RATIO, 8'h35, 8'h35);
      repeat (3) tick;
      ck({7'h0, wen}, 8'h00);
      close_want = 1'b0;
      repeat (3) tick;
      close_want = 1'b1;
      repeat (3) tick;
      ck({7'h0, wen}, 8'h01);
      $display("test 6 done");
      wc(1, `WCSS_SEL_OWNER, 8'h01, 8'h01);
      wc(0, `WCSS_SEL_RATIO, 8'h07, 8'h35);
      wc(0, `WCSS_SEL_OWNER, 8'h00, 8'h00);
      pe(0);
      ck(ratio, 8'h01);
      ck({3'h0, addr}, 8'h01);
      ck({7'h0, link}, 8'h01);
      pe(5);
      ck({7'h0, flt}, 8'h01);
      $display("test 7 done");
      // Mid-run reset with the valve strap set to the large option
      strap = 1'b1;
      i_srst = 1'b1;
      repeat (2) tick;
      i_srst = 1'b0;
      ck({4'h0, valves}, 8'h0C);
      ck({7'h0, led}, 8'h00);
      ck({7'h0, flt}, 8'h00);
      ck({7'h0, wen}, 8'h00);
      ck({7'h0, link}, 8'h01);
      wc(0, `WCSS_SEL_VALVES, 8'h04, 8'h04);
      pe(0);
      ck({4'h0, valves}, 8'h0C);
      $display("test 8 done");
      close_out();
   end
   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #50000;
      err_total++;
      close_out();
   end
endmodule
bind wcss_settings wcss_props u_props (.i_clock, .i_srst, .i_panel_req, .i_host_req,
   .i_restore_defaults, .i_weld_start, .i_half_cycle_end, .i_weld_end, .i_start,
   .i_panel_reset, .i_reset_input, .i_error_reset, .i_step_reset, .o_transformer_ratio,
   .o_regulation_mode, .o_fire_limit_87, .o_cycle_complete, .o_stepper_complete,
   .o_step_counter_clear, .o_start_accept, .o_error_led, .o_fault_output);
